// ==== frd_decoder.sv ====
/*
  Peripheral frame decoder: steers processor and DMA accesses to one
  register region, gates protected writes and inserts wait states.
  Assumes masters hold a request steady until its acknowledge pulse, and
  that the protection instructions arrive as one-cycle pulses.
*/
// Overview of operation
// - Frame zero routed on processor memory bus.
// - Frame one routed to 32-bit peripheral bus.
// - Frame two routed to 16-bit peripheral bus.
// - Frame three on 32-bit bus, DMA reachable.
// - Frame zero takes 16 and 32-bit accesses.
// - Protected writes dropped until protection lifted.
// - Restore instruction blocks protected writes again.
// - Flash writes also blocked while security locked.
// - Converter results read-only, DMA 0, CPU 1 wait.
// - Emulation region decoded, write protected.
// - Flash region decoded, write protected.
// - Code security region decoded, write protected.
// - External memory interface region decoded, protected.
// - Timer region decoded, writes always allowed.
// - Interrupt expansion region decoded, writes allowed.
// - Vector table region decoded, write protected.
// - DMA register region decoded, write protected.
// - Six pulse-width windows of 64 words.
// - Six capture windows of 32 words.
// - System control region decoded on 16-bit bus.
// - Remap bit moves pulse-width modules to frame three.
`timescale 1ns/1ns
`default_nettype none

module frd_decoder
  import frd_pkg::*;
(
  input  wire logic          CLOCK,
  input  wire logic          RSTN,
  input  wire logic          CPU_REQ,
  input  wire frd_addr_type  CPU_ADDR,
  input  wire logic          CPU_WR,
  input  wire logic          CPU_WIDE,
  input  wire logic          CPU_WDATA_LSB,
  input  wire logic          DMA_REQ,
  input  wire frd_addr_type  DMA_ADDR,
  input  wire logic          DMA_WR,
  input  wire logic          DMA_WIDE,
  input  wire logic          PROT_LIFT,
  input  wire logic          PROT_RESTORE,
  input  wire logic          SEC_LOCKED,
  output logic               CPU_ACK,
  output logic               DMA_ACK,
  output logic [NUM_REG-1:0] REGION_SEL,
  output frd_frame_type      FRAME_SEL,
  output frd_addr_type       BUS_ADDR,
  output logic               BUS_WR,
  output logic               BUS_WIDE,
  output logic               BUS_DMA,
  output logic               WR_BLOCKED,
  output logic               NO_TARGET,
  output logic               PROT_OPEN,
  output logic               PWM_REMAP
);

  frd_wait_if wt ();  // Wait-state handshake.

  logic               open_q;      // Protection lifted.
  logic               remap_q;     // Pulse-width modules in frame three.
  logic               owner_dma_q; // Master of the held access.
  logic               grant_dma;   // DMA request taken this cycle.
  logic               grant_cpu;   // Processor request taken this cycle.
  logic               accept;      // Some request taken this cycle.
  frd_addr_type       acc_addr;    // Address of the chosen request.
  logic               acc_wr;      // Chosen request writes.
  logic               acc_wide;    // Chosen request is 32 bits wide.
  logic [NUM_F0-1:0]  f0_hit;      // Frame zero region hits.
  logic [NUM_PWM-1:0] pwm1_hit;    // Pulse-width hits at frame one.
  logic [NUM_PWM-1:0] pwm3_hit;    // Pulse-width hits at frame three.
  logic [NUM_PWM-1:0] pwm_hit;     // Pulse-width hits in the live frame.
  logic [NUM_CAP-1:0] cap_hit;     // Capture module hits.
  logic               sys_hit;     // System control hit.
  logic [NUM_REG-1:0] region_hit;  // All hits, one-hot or zero.
  frd_frame_type      frame_d;     // Route of the chosen request.
  logic               prot_hit;    // Target word is write protected.
  logic               blocked_d;   // Write must be dropped.
  logic               refuse_d;    // Access reaches no region.
  logic               pass_d;      // Access goes out to a region.
  logic [WAIT_W-1:0]  wait_d;      // Wait states for this access.

  // The DMA engine wins a tie, as it feeds time-critical peripherals.
  // A master whose acknowledge is showing is not taken again that edge.
  always_comb begin
    grant_dma = DMA_REQ && !DMA_ACK && !wt.busy;
    grant_cpu = CPU_REQ && !CPU_ACK && !wt.busy && !grant_dma;
    accept    = grant_dma || grant_cpu;
    acc_addr  = grant_dma ? DMA_ADDR : CPU_ADDR;
    acc_wr    = grant_dma ? DMA_WR : CPU_WR;
    acc_wide  = grant_dma ? DMA_WIDE : CPU_WIDE;
  end

  // One window comparator per frame zero region.
  for (genvar i = 0; i < NUM_F0; i++) begin : g_f0
    frd_range_match #(.BASE(F0_BASE[i]), .LAST(F0_LAST[i])) u_match (
      .addr (acc_addr),
      .hit  (f0_hit[i])
    );
  end

  // Pulse-width windows exist at both frames; the remap bit picks one.
  for (genvar i = 0; i < NUM_PWM; i++) begin : g_pwm
    localparam frd_addr_type OFS = frd_addr_type'(i) * PWM_WORDS;
    frd_range_match #(.BASE(PWM_F1_BASE + OFS),
                      .LAST(PWM_F1_BASE + OFS + PWM_WORDS - 22'h000001)) u_f1 (
      .addr (acc_addr),
      .hit  (pwm1_hit[i])
    );
    frd_range_match #(.BASE(PWM_F3_BASE + OFS),
                      .LAST(PWM_F3_BASE + OFS + PWM_WORDS - 22'h000001)) u_f3 (
      .addr (acc_addr),
      .hit  (pwm3_hit[i])
    );
  end

  // Capture modules sit back to back from the first base.
  for (genvar i = 0; i < NUM_CAP; i++) begin : g_cap
    localparam frd_addr_type OFS = frd_addr_type'(i) * CAP_WORDS;
    frd_range_match #(.BASE(CAP_BASE + OFS),
                      .LAST(CAP_BASE + OFS + CAP_WORDS - 22'h000001)) u_match (
      .addr (acc_addr),
      .hit  (cap_hit[i])
    );
  end

  // System control window on the narrow bus.
  frd_range_match #(.BASE(SYS_BASE), .LAST(SYS_LAST)) u_sys (
    .addr (acc_addr),
    .hit  (sys_hit)
  );

  // Route and gate the chosen access. The windows never overlap, so the
  // hit vector is one-hot or empty without any priority logic.
  always_comb begin
    pwm_hit    = remap_q ? pwm3_hit : pwm1_hit;
    region_hit = {sys_hit, cap_hit, pwm_hit, f0_hit};
    if (|f0_hit) begin
      frame_d = FRAME_ZERO;
    end else if ((|pwm_hit) && remap_q) begin
      frame_d = FRAME_THREE;
    end else if ((|pwm_hit) || (|cap_hit)) begin
      frame_d = FRAME_ONE;
    end else if (sys_hit) begin
      frame_d = FRAME_TWO;
    end else begin
      frame_d = FRAME_NONE;
    end
    prot_hit  = (|(f0_hit & F0_PROTECTED)) || (acc_addr == REMAP_ADDR);
    blocked_d = acc_wr && ((prot_hit && !open_q)
                           || f0_hit[IDX_ADC]
                           || (f0_hit[IDX_FLASH] && SEC_LOCKED));
    // The DMA engine reaches only frame three and the converter results;
    // a wide access cannot be carried by the narrow bus.
    refuse_d  = (frame_d == FRAME_NONE)
                || (grant_dma && !f0_hit[IDX_ADC] && frame_d != FRAME_THREE)
                || (acc_wide && frame_d == FRAME_TWO);
    pass_d    = !refuse_d && !blocked_d;
    if (pass_d && f0_hit[IDX_ADC]) begin
      wait_d = grant_dma ? WAIT_DMA_ADC : WAIT_CPU_ADC;
    end else begin
      wait_d = WAIT_NONE;
    end
    wt.start  = accept && (wait_d != WAIT_NONE);
    wt.cycles = wait_d;
  end

  frd_wait_timer u_wait (
    .clk   (CLOCK),
    .rst_n (RSTN),
    .wt    (wt)
  );

  // Protection flag. Restore wins a tie so that stray code stays fenced.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      open_q <= 1'b0;
    end else if (PROT_RESTORE) begin
      open_q <= 1'b0;
    end else if (PROT_LIFT) begin
      open_q <= 1'b1;
    end
  end

  // Shadow of the remap bit, caught from passing processor writes. The
  // access that writes it is still decoded with the old setting.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      remap_q <= 1'b0;
    end else if (grant_cpu && acc_wr && pass_d && acc_addr == REMAP_ADDR) begin
      remap_q <= CPU_WDATA_LSB;
    end
  end

  // Select and bus outputs; they stand through any wait states, and all but
  // BUS_ADDR and BUS_DMA clear when the timer goes idle with nothing new taken.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      REGION_SEL  <= '0;
      FRAME_SEL   <= FRAME_NONE;
      BUS_ADDR    <= '0;
      BUS_WR      <= 1'b0;
      BUS_WIDE    <= 1'b0;
      BUS_DMA     <= 1'b0;
      owner_dma_q <= 1'b0;
    end else if (accept) begin
      REGION_SEL  <= pass_d ? region_hit : '0;
      FRAME_SEL   <= pass_d ? frame_d : FRAME_NONE;
      BUS_ADDR    <= acc_addr;
      BUS_WR      <= acc_wr && pass_d;
      BUS_WIDE    <= acc_wide && pass_d;
      BUS_DMA     <= grant_dma;
      owner_dma_q <= grant_dma;
    end else if (!wt.busy) begin
      REGION_SEL  <= '0;
      FRAME_SEL   <= FRAME_NONE;
      BUS_WR      <= 1'b0;
      BUS_WIDE    <= 1'b0;
    end
  end

  // Acknowledges: at once without wait states, else on the expire edge.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      CPU_ACK <= 1'b0;
      DMA_ACK <= 1'b0;
    end else begin
      CPU_ACK <= (grant_cpu && wait_d == WAIT_NONE) || (wt.expire && !owner_dma_q);
      DMA_ACK <= (grant_dma && wait_d == WAIT_NONE) || (wt.expire && owner_dma_q);
    end
  end

  // Error pulses ride with the acknowledge of the refused access.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      WR_BLOCKED <= 1'b0;
      NO_TARGET  <= 1'b0;
    end else begin
      WR_BLOCKED <= accept && !refuse_d && blocked_d;
      NO_TARGET  <= accept && refuse_d;
    end
  end

  // Status copies for the rest of the chip.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      PROT_OPEN <= 1'b0;
      PWM_REMAP <= 1'b0;
    end else begin
      PROT_OPEN <= open_q;
      PWM_REMAP <= remap_q;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  sequence s_cpu_adc_read;
    grant_cpu && f0_hit[IDX_ADC] && !acc_wr && !refuse_d;
  endsequence
  sequence s_held_then_ack;
    (!CPU_ACK && REGION_SEL[IDX_ADC]) ##1 (CPU_ACK && REGION_SEL[IDX_ADC]);
  endsequence

  a_prot_write_drop: assert property (
    accept && acc_wr && prot_hit && !open_q && !refuse_d
    |=> WR_BLOCKED && REGION_SEL == '0 && !BUS_WR)
    else $error("Protected write passed while protection was closed.");
  a_restore_closes: assert property (
    PROT_RESTORE |=> !open_q ##1 !PROT_OPEN)
    else $error("Protection still open after restore.");
  a_flash_lock_gate: assert property (
    accept && acc_wr && !refuse_d && f0_hit[IDX_FLASH] && SEC_LOCKED |=> WR_BLOCKED)
    else $error("Flash write passed while security was locked.");
  a_adc_cpu_wait: assert property (
    s_cpu_adc_read |=> s_held_then_ack)
    else $error("Processor converter read lacks its single wait state.");
  a_adc_dma_nowait: assert property (
    grant_dma && f0_hit[IDX_ADC] && !acc_wr |=> DMA_ACK && REGION_SEL[IDX_ADC])
    else $error("DMA converter read was not answered at once.");
  a_adc_read_only: assert property (
    accept && acc_wr && f0_hit[IDX_ADC] |=> WR_BLOCKED && !BUS_WR)
    else $error("Write reached the converter results region.");
  a_timer_write_open: assert property (
    grant_cpu && acc_wr && f0_hit[IDX_TIMER] |=> REGION_SEL[IDX_TIMER] && BUS_WR)
    else $error("Timer write was not passed through.");
  a_single_select: assert property (
    $onehot0(REGION_SEL) && ((REGION_SEL == '0) == (FRAME_SEL == FRAME_NONE)))
    else $error("Select vector and frame route disagree.");
  a_pwm_frame_route: assert property (
    (|REGION_SEL[IDX_PWM0 +: NUM_PWM])
    |-> FRAME_SEL == (PWM_REMAP ? FRAME_THREE : FRAME_ONE))
    else $error("Pulse-width access on the wrong frame.");
  a_narrow_sys_bus: assert property (
    REGION_SEL[IDX_SYS] |-> FRAME_SEL == FRAME_TWO && !BUS_WIDE)
    else $error("System control access not on the narrow bus.");

endmodule // frd_decoder

`default_nettype wire

// ==== frd_pkg.sv ====
/*
  Constants and types shared by the peripheral frame decoder files.
  Assumes word addresses of 22 bits, one address per 16-bit word.
*/
`default_nettype none

package frd_pkg;

  // Width of a word address on the processor and DMA buses.
  localparam int ADDR_W = 22;
  typedef logic [ADDR_W-1:0] frd_addr_type;

  // Region counts and positions inside the select vector.
  localparam int NUM_F0    = 9;
  localparam int NUM_PWM   = 6;
  localparam int NUM_CAP   = 6;
  localparam int NUM_REG   = 22;
  localparam int IDX_EMU   = 0;
  localparam int IDX_FLASH = 1;
  localparam int IDX_SEC   = 2;
  localparam int IDX_ADC   = 3;
  localparam int IDX_EMIF  = 4;
  localparam int IDX_TIMER = 5;
  localparam int IDX_INTX  = 6;
  localparam int IDX_VEC   = 7;
  localparam int IDX_DMA   = 8;
  localparam int IDX_PWM0  = 9;
  localparam int IDX_CAP0  = 15;
  localparam int IDX_SYS   = 21;

  // Frame zero regions, first and last word, in index order.
  localparam frd_addr_type F0_BASE [NUM_F0] = '{
    22'h000880, 22'h000a80, 22'h000ae0, 22'h000b00, 22'h000b20,
    22'h000c00, 22'h000ce0, 22'h000d00, 22'h001000};
  localparam frd_addr_type F0_LAST [NUM_F0] = '{
    22'h0009ff, 22'h000adf, 22'h000aef, 22'h000b0f, 22'h000b3f,
    22'h000c3f, 22'h000cff, 22'h000dff, 22'h0011ff};

  // Frame zero regions whose writes need the protection to be lifted.
  localparam logic [NUM_F0-1:0] F0_PROTECTED = 9'h197;

  // Pulse-width, capture and system control windows.
  localparam frd_addr_type PWM_F1_BASE = 22'h006800;
  localparam frd_addr_type PWM_F3_BASE = 22'h005800;
  localparam frd_addr_type PWM_WORDS   = 22'h000040;
  localparam frd_addr_type CAP_BASE    = 22'h006a00;
  localparam frd_addr_type CAP_WORDS   = 22'h000020;
  localparam frd_addr_type SYS_BASE    = 22'h007010;
  localparam frd_addr_type SYS_LAST    = 22'h00702f;

  // Remap configuration register word and its remap bit.
  localparam frd_addr_type REMAP_ADDR = 22'h00702e;
  localparam int           REMAP_BIT  = 0;

  // Wait states of the dual-mapped converter results region.
  localparam int         WAIT_W       = 2;
  localparam logic [1:0] WAIT_CPU_ADC = 2'h1;
  localparam logic [1:0] WAIT_DMA_ADC = 2'h0;
  localparam logic [1:0] WAIT_NONE    = 2'h0;

  // One-hot route of an access.
  typedef enum logic [3:0] {
    FRAME_NONE  = 4'h0,
    FRAME_ZERO  = 4'h1,
    FRAME_ONE   = 4'h2,
    FRAME_TWO   = 4'h4,
    FRAME_THREE = 4'h8
  } frd_frame_type;

endpackage

`default_nettype wire

// ==== frd_wait_if.sv ====
/*
  Handshake between the decoder and its wait-state timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

interface frd_wait_if;
  import frd_pkg::*;
  logic              start;   // Loads the timer, one-cycle pulse.
  logic [WAIT_W-1:0] cycles;  // Wait states to insert, nonzero on start.
  logic              busy;    // Timer is counting.
  logic              expire;  // Last wait cycle.
  modport ctrl  (output start, output cycles, input busy, input expire);
  modport timer (input start, input cycles, output busy, output expire);
endinterface

`default_nettype wire

// ==== frd_range_match.sv ====
/*
  Compares one word address against an inclusive address window.
  Assumes the window bounds are constants fixed at elaboration.
*/
`timescale 1ns/1ns
`default_nettype none

module frd_range_match
  import frd_pkg::*;
#(
  parameter frd_addr_type BASE = '0,
  parameter frd_addr_type LAST = '0
) (
  input  wire frd_addr_type addr,
  output logic              hit
);

  // Pure comparison, so the decoder keeps one registered stage only.
  always_comb begin
    hit = (addr >= BASE) && (addr <= LAST);
  end

endmodule // frd_range_match

`default_nettype wire

// ==== frd_wait_timer.sv ====
/*
  Down counter that inserts wait states for a held access.
  Assumes start arrives only while the timer is idle.
*/
`timescale 1ns/1ns
`default_nettype none

module frd_wait_timer
  import frd_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  frd_wait_if.timer wt
);

  logic [WAIT_W-1:0] cnt_q;  // Remaining wait cycles.

  // Load on start, then count down to idle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (wt.start) begin
      cnt_q <= wt.cycles;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end

  // The expire cycle is still busy, which keeps the select standing.
  always_comb begin
    wt.busy   = (cnt_q != '0);
    wt.expire = (cnt_q == 2'h1);
  end

endmodule // frd_wait_timer

`default_nettype wire

// ==== frd_master_model.sv ====
/*
  Behavioural model of one bus master, the processor or the DMA engine.
  Assumes the decoder answers a held request with a one-cycle acknowledge.
*/
`timescale 1ns/1ns
`default_nettype none

module frd_master_model
  import frd_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         go,
  input  wire frd_addr_type c_addr,
  input  wire logic         c_wr,
  input  wire logic         c_wide,
  input  wire logic         c_lsb,
  input  wire logic         ack,
  output logic              req_q,
  output frd_addr_type      addr_q,
  output logic              wr_q,
  output logic              wide_q,
  output logic              lsb_q,
  output logic [2:0]        lat_q
);
  logic fin_q;  // The acknowledge was seen at the last rising edge.

  // All lines start quiet so the decoder sees no request at time zero.
  initial begin
    req_q = 1'b0;
    addr_q = '0;
    wr_q = 1'b0;
    wide_q = 1'b0;
    lsb_q = 1'b0;
    lat_q = 3'h0;
    fin_q = 1'b0;
  end

  // Counts the rising edges spent waiting and notes the answering edge.
  // Idle edges clear the count, so each request starts from zero.
  always @(posedge clk) begin
    if (!req_q) begin
      fin_q <= 1'b0;
      lat_q <= 3'h0;
    end else if (ack) begin
      fin_q <= 1'b1;
    end else begin
      lat_q <= lat_q + 3'h1;
    end
  end

  // Requests start and end on the falling edge; released lines flip so a
  // stale value can never pass for a held one.
  always @(negedge clk) begin
    if (fin_q) begin
      req_q <= 1'b0;
      addr_q <= ~addr_q;
      wr_q <= ~wr_q;
      wide_q <= ~wide_q;
      lsb_q <= ~lsb_q;
    end else if (go && !req_q) begin
      req_q <= 1'b1;
      addr_q <= c_addr;
      wr_q <= c_wr;
      wide_q <= c_wide;
      lsb_q <= c_lsb;
    end
  end
endmodule // frd_master_model

`default_nettype wire

// ==== testbench.sv ====
/*
  Self-checking bench for the peripheral frame decoder.
  Assumes two master models drive the request side and one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none

`define FRD_CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module testbench
  import frd_pkg::*;
;
  localparam frd_addr_type F0B [9] = '{22'h880, 22'ha80, 22'hae0, 22'hb00, 22'hb20,
                                       22'hc00, 22'hce0, 22'hd00, 22'h1000};
  localparam frd_addr_type F0L [9] = '{22'h9ff, 22'hadf, 22'haef, 22'hb0f, 22'hb3f,
                                       22'hc3f, 22'hcff, 22'hdff, 22'h11ff};
  logic clk, rstn, prot_lift, prot_restore, sec_lock; // Bench-driven design inputs.
  logic go_q [2];                                    // Start strobes, index 1 is DMA.
  frd_addr_type c_addr [2];                          // Commands for the two masters.
  logic c_wr [2], c_wide [2], c_lsb [2];
  logic req [2], wr [2], wide [2], lsb [2];          // Master request lines.
  frd_addr_type addr [2];
  logic [2:0] lat [2];                               // Edges each master waited.
  logic cpu_ack, dma_ack, bus_wr, bus_wide, bus_dma, wr_blocked, no_target;
  logic prot_open, pwm_remap;
  logic [NUM_REG-1:0] region_sel;
  frd_addr_type bus_addr;
  frd_frame_type frame_sel;
  logic [55:0] note_q [$];                           // Expected answers, oldest first.
  logic [55:0] e, got;                               // {address, wide out, decode}.
  logic [32:0] r;
  logic remap_m, open_m;                             // Reference copies of the state.
  int miscompares, total_checks, seed;

  frd_decoder i_frd_decoder (.CLOCK(clk), .RSTN(rstn), .CPU_REQ(req[0]),
    .CPU_ADDR(addr[0]), .CPU_WR(wr[0]), .CPU_WIDE(wide[0]), .CPU_WDATA_LSB(lsb[0]),
    .DMA_REQ(req[1]), .DMA_ADDR(addr[1]), .DMA_WR(wr[1]), .DMA_WIDE(wide[1]),
    .PROT_LIFT(prot_lift), .PROT_RESTORE(prot_restore), .SEC_LOCKED(sec_lock),
    .CPU_ACK(cpu_ack), .DMA_ACK(dma_ack), .REGION_SEL(region_sel), .FRAME_SEL(frame_sel),
    .BUS_ADDR(bus_addr), .BUS_WR(bus_wr), .BUS_WIDE(bus_wide), .BUS_DMA(bus_dma),
    .WR_BLOCKED(wr_blocked), .NO_TARGET(no_target), .PROT_OPEN(prot_open),
    .PWM_REMAP(pwm_remap));

  // One model per master; the DMA one sits at index 1 and wins ties.
  for (genvar m = 0; m < 2; m++) begin : g_master
    frd_master_model i_frd_master_model (.clk(clk), .go(go_q[m]), .c_addr(c_addr[m]),
      .c_wr(c_wr[m]), .c_wide(c_wide[m]), .c_lsb(c_lsb[m]), .ack(m ? dma_ack : cpu_ack),
      .req_q(req[m]), .addr_q(addr[m]), .wr_q(wr[m]), .wide_q(wide[m]), .lsb_q(lsb[m]),
      .lat_q(lat[m]));
  end

  // Clock at 20 MHz.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Reference decode: {dma, wait, select, frame, write out, blocked, refused}.
  function automatic logic [32:0] expect_of(input logic dma, input frd_addr_type a,
                                            input logic w, input logic wd);
    int idx;
    logic [3:0] fr;
    logic nt, wb, pr;
    frd_addr_type pb;
    idx = -1;
    fr = 4'h0;
    pb = remap_m ? 22'h5800 : 22'h6800;
    for (int i = 0; i < 9; i++) begin
      if (a >= F0B[i] && a <= F0L[i]) begin
        idx = i;
        fr = 4'h1;
      end
    end
    if (a >= pb && a < pb + 22'h180) begin
      idx = 9 + int'((a - pb) >> 6);
      fr = remap_m ? 4'h8 : 4'h2;
    end
    if (a >= 22'h6a00 && a <= 22'h6abf) begin
      idx = 15 + int'((a - 22'h6a00) >> 5);
      fr = 4'h2;
    end
    if (a >= 22'h7010 && a <= 22'h702f) begin
      idx = 21;
      fr = 4'h4;
    end
    pr = (idx inside {0, 1, 2, 4, 7, 8}) || a == 22'h702e;
    nt = idx < 0 || (dma && fr != 4'h8 && idx != 3) || (wd && fr == 4'h4);
    wb = !nt && w && (idx == 3 || (pr && !open_m) || (idx == 1 && sec_lock));
    // A dropped or refused access routes to no frame at all.
    return {dma, (!dma && !w && idx == 3) ? 3'h2 : 3'h1,
            (nt || wb) ? 22'h0 : 22'h1 << idx,
            (nt || wb) ? 4'h0 : fr, w && !nt && !wb, wb, nt};
  endfunction

  // Records the expected answer and loads one master's command.
  task automatic note(input logic dma, input frd_addr_type a, input logic w,
                      input logic wd, input logic l, input logic [2:0] extra);
    logic [32:0] x;
    x = expect_of(dma, a, w, wd);
    x[31:29] = x[31:29] + extra;
    note_q.push_back({a, wd && (x[28:7] != 22'h0), x});
    c_addr[dma] = a;
    c_wr[dma] = w;
    c_wide[dma] = wd;
    c_lsb[dma] = l;
    if (!dma && w && a == 22'h702e && x[2]) begin
      remap_m = l;
    end
  endtask

  // Starts the chosen masters and waits, bounded, until both are released.
  task automatic launch(input logic c, input logic d);
    @(negedge clk);
    go_q[0] <= c;
    go_q[1] <= d;
    @(negedge clk);
    go_q[0] <= 1'b0;
    go_q[1] <= 1'b0;
    #1;
    for (int n = 0; n < 10 && (req[0] || req[1]); n++) begin
      @(negedge clk);
      #1;
    end
    // A request still waiting here was never answered.
    if (req[0] || req[1]) begin
      miscompares++;
    end
  endtask

  task automatic acc(input logic dma, input frd_addr_type a, input logic w,
                     input logic wd, input logic l);
    note(dma, a, w, wd, l, 3'h0);
    launch(!dma, dma);
  endtask

  // Pulses one protection instruction and checks the open flag after it.
  task automatic prot(input logic lift);
    @(negedge clk);
    prot_lift <= lift;
    prot_restore <= !lift;
    @(negedge clk);
    prot_lift <= 1'b0;
    prot_restore <= 1'b0;
    repeat (2) @(negedge clk);
    open_m = lift;
    `FRD_CHK(33'(prot_open), 33'(lift))
  endtask

  task automatic complete_run;
    $display("checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Every acknowledge takes the oldest note and compares all bus outputs with it.
  always @(negedge clk) begin
    if (cpu_ack || dma_ack) begin
      e = (note_q.size() > 0) ? note_q.pop_front() : 'x;
      got = {bus_addr, bus_wide, bus_dma, dma_ack ? lat[1] : lat[0], region_sel, frame_sel,
             bus_wr, wr_blocked, no_target};
      `FRD_CHK(got, e)
    end
  end

  // Watchdog sized well beyond the few hundred cycles the tests need.
  initial begin
    #(50 * 6000);
    miscompares++;
    complete_run;
  end

  // Main sequence.
  initial begin
    {rstn, prot_lift, prot_restore, sec_lock, remap_m, open_m} = 6'h0;
    for (int m = 0; m < 2; m++) begin
      {go_q[m], c_wr[m], c_wide[m], c_lsb[m], c_addr[m]} = '0;
    end
    seed = 38;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    `FRD_CHK(33'({prot_open, pwm_remap, region_sel}), 33'h0)
    for (int i = 0; i < 9; i++) begin
      acc(1'b0, F0B[i], 1'b0, i[0], 1'b0);
      acc(1'b0, F0L[i], 1'b1, !i[0], 1'b0);
      acc(1'b0, F0L[i] + 22'h1, 1'b0, 1'b0, 1'b0);
    end
    acc(1'b1, 22'hb05, 1'b0, 1'b1, 1'b0);
    acc(1'b1, 22'h6800, 1'b0, 1'b0, 1'b0);
    prot(1'b1);
    sec_lock = 1'b1;
    for (int i = 0; i < 9; i++) begin
      acc(1'b0, F0B[i], 1'b1, i[0], 1'b1);
    end
    sec_lock = 1'b0;
    acc(1'b0, 22'ha80, 1'b1, 1'b1, 1'b0);
    acc(1'b0, 22'h702e, 1'b1, 1'b0, 1'b1);
    `FRD_CHK(33'(pwm_remap), 33'h1)
    for (int i = 0; i < 6; i++) begin
      acc(i[0], 22'h5800 + 22'(i * 64) + 22'h3f, i[1], 1'b1, 1'b0);
    end
    acc(1'b0, 22'h702e, 1'b1, 1'b0, 1'b0);
    prot(1'b0);
    acc(1'b0, 22'h1000, 1'b1, 1'b1, 1'b0);
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, 22'h6800 + 22'(i * 64), 1'b0, 1'b1, 1'b0);
      acc(1'b0, 22'h6a00 + 22'(i * 32) + 22'h1f, 1'b1, 1'b0, 1'b0);
    end
    acc(1'b0, 22'h7010, 1'b1, 1'b0, 1'b0);
    acc(1'b0, 22'h702f, 1'b0, 1'b1, 1'b0);
    note(1'b1, 22'hb00, 1'b0, 1'b0, 1'b0, 3'h0);
    note(1'b0, 22'hc10, 1'b1, 1'b1, 1'b0, 3'h1);
    launch(1'b1, 1'b1);
    repeat (40) begin
      r = 33'($random(seed));
      sec_lock = r[4];
      acc(r[0], frd_addr_type'(r[30:16]), r[1], r[2], r[3]);
    end
    `FRD_CHK(33'(note_q.size()), 33'h0)
    complete_run;
  end
endmodule // testbench

`default_nettype wire
